// ---- core/cmd_handler.sv ----
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
// What this block does
// R1 - clear-status empties queues, status byte, event register
// R2 - reset also zeroes both enable masks
// R3 - reset drops talker and listener addressing
// R4 - completion command sets event bit 0
// R5 - service request only when both masks allow; the timeout, bus error and message bits need only sre here
// R6 - completion query answers 1
// R7 - wait command accepted, does nothing
// R8 - target select takes address 1 to 30
// R9 - absent unit at target raises no error
// R10 - target address defaults to 1
// R11 - host returns target to 1 when done
// R12 - mode codes: 0 local, 1 remote, 2 lockout
// R13 - mode query while local enters remote first
// R14 - query forms of setting-only commands are errors
module cmd_handler
  import cmd_handler_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire cmd_t cmd,
  output resp_t resp,
  output flush_t flush,
  input wire logic panel_local_key,
  input wire logic talk_set,
  input wire logic listen_set,
  input wire logic exe_event,
  input wire logic alarm_event,
  input wire logic timeout_event,
  input wire logic lbus_err_event,
  input wire logic msg_avail,
  output logic talk_en,
  output logic listen_en,
  output logic [4:0] target_addr,
  output logic [1:0] control_mode,
  output logic srq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  state_t st_ff;
  state_t nxt_st;

  logic [7:0] stb_low;
  logic [7:0] stb;
  logic mss;
  logic is_clear;
  logic is_reset;
  logic setting_only;
  logic cmd_err;
  logic key_press;
  logic [EV_W-1:0] ev_set;
  logic [1:0] mode_wr;

  ////////////////////////////////////////////////////////////////////////////
  // status byte summary and service request
  always_comb begin
    stb_low = 8'h00;
    stb_low[STB_TMO] = st_ff.tmo;
    stb_low[STB_LERR] = st_ff.lerr;
    stb_low[STB_MAV] = msg_avail;
    stb_low[STB_ESB] = |(st_ff.esr & st_ff.ese); // [R5]
    mss = |(stb_low & st_ff.sre & STB_SUMMARY_MASK); // [R5]
    stb = stb_low;
    stb[STB_MSS] = mss;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command classification
  always_comb begin
    is_clear = cmd.valid && !cmd.query &&
      (cmd.code == CMD_CLEAR_STATUS || cmd.code == CMD_RESET); // [R1] [R2]
    is_reset = cmd.valid && !cmd.query && cmd.code == CMD_RESET; // [R2]
    setting_only = cmd.code == CMD_CLEAR_STATUS || cmd.code == CMD_RESET ||
      cmd.code == CMD_WAIT || cmd.code == CMD_TARGET_SELECT;
    cmd_err = cmd.valid && ((cmd.query && setting_only) ||
      (!cmd.query && cmd.code == CMD_CONTROL_MODE && cmd.arg > 8'h02) ||
      (cmd.code > CMD_CONTROL_MODE)); // [R14] [R12]
    // settled high in stages two and three while the filtered level is still low
    key_press = !st_ff.key_level && st_ff.key_sync[1] && st_ff.key_sync[2];
    mode_wr = reg_wdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    ev_set = '0;
    nxt_st.resp.valid = 1'b0;
    nxt_st.flush = '0;

    // panel key: three stages, a change counts once stages two and three agree
    nxt_st.key_sync = {st_ff.key_sync[1:0], panel_local_key};
    if (st_ff.key_sync[1] == st_ff.key_sync[2]) begin
      nxt_st.key_level = st_ff.key_sync[2];
    end
    // rising key level returns to local, except under lockout
    if (key_press && st_ff.mode == MODE_REMOTE) begin // [R12]
      nxt_st.mode = MODE_LOCAL;
      ev_set[EV_MODE] = 1'b1;
    end

    // talker and listener addressing from the bus interface
    if (talk_set) begin
      nxt_st.talk = 1'b1;
      nxt_st.listen = 1'b0;
    end
    if (listen_set) begin
      nxt_st.listen = 1'b1;
    end

    // clear-status and reset share the clearing work
    if (is_clear) begin
      nxt_st.flush = '{tx: 1'b1, rx: 1'b1, lbus: 1'b1, exec: 1'b1}; // [R1]
      nxt_st.esr = 8'h00; // [R1]
      nxt_st.tmo = 1'b0; // [R1]
      nxt_st.lerr = 1'b0; // [R1]
      ev_set[EV_CLEAR] = 1'b1;
    end
    if (is_reset) begin
      nxt_st.ese = 8'h00; // [R2]
      nxt_st.sre = 8'h00; // [R2]
      nxt_st.talk = 1'b0; // [R3]
      nxt_st.listen = 1'b0; // [R3]
      ev_set[EV_RESET] = 1'b1;
    end

    if (cmd.valid && !cmd_err) begin
      case (cmd.code)
        CMD_OP_COMPLETE: begin
          if (cmd.query) begin
            nxt_st.resp.valid = 1'b1; // [R6]
            nxt_st.resp.data = OPC_ANSWER; // [R6]
          end else begin
            nxt_st.esr[ESR_OPC] = 1'b1; // [R4]
            ev_set[EV_OPC] = 1'b1;
          end
        end
        CMD_WAIT: begin
          nxt_st.esr = nxt_st.esr; // [R7] all commands overlap, nothing to do
        end
        CMD_TARGET_SELECT: begin
          // presence of a unit is never checked, so no error for empty slots
          if (cmd.arg >= {3'h0, TARGET_MIN} && cmd.arg <= {3'h0, TARGET_MAX}) begin
            nxt_st.target = cmd.arg[4:0]; // [R8] [R9]
            ev_set[EV_TARGET] = 1'b1;
          end else begin
            nxt_st.esr[ESR_EXE] = 1'b1; // [R8]
          end
        end
        CMD_CONTROL_MODE: begin
          if (cmd.query) begin
            nxt_st.resp.valid = 1'b1;
            if (st_ff.mode == MODE_LOCAL) begin
              nxt_st.mode = MODE_REMOTE; // [R13]
              nxt_st.resp.data = {6'h00, MODE_REMOTE}; // [R13]
              ev_set[EV_MODE] = 1'b1;
            end else begin
              nxt_st.resp.data = {6'h00, st_ff.mode};
            end
          end else begin
            nxt_st.mode = cmd.arg[1:0]; // [R12]
            ev_set[EV_MODE] = 1'b1;
          end
        end
        default: begin
          nxt_st.esr = nxt_st.esr;
        end
      endcase
    end
    if (cmd_err) begin
      nxt_st.esr[ESR_CME] = 1'b1; // [R14]
      ev_set[EV_CMD_ERR] = 1'b1;
    end

    // outside events set their bits; a set wins over a same-cycle clear
    if (exe_event) begin
      nxt_st.esr[ESR_EXE] = 1'b1;
    end
    if (alarm_event) begin
      nxt_st.esr[ESR_ALM] = 1'b1;
    end
    if (timeout_event) begin
      nxt_st.tmo = 1'b1;
    end
    if (lbus_err_event) begin
      nxt_st.lerr = 1'b1;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_EVT_STAT: nxt_st.ev_stat = st_ff.ev_stat & ~reg_wdata[EV_W-1:0];
        OFS_EVT_MASK: nxt_st.ev_mask = reg_wdata[EV_W-1:0];
        OFS_ESE: begin
          if (!is_reset) begin
            nxt_st.ese = reg_wdata[7:0];
          end
        end
        OFS_SRE: begin
          if (!is_reset) begin
            nxt_st.sre = reg_wdata[7:0];
          end
        end
        OFS_MODE: begin
          if (mode_wr <= MODE_LOCKOUT) begin
            nxt_st.mode = mode_wr; // [R12]
            ev_set[EV_MODE] = 1'b1;
          end
        end
        default: nxt_st.ev_mask = nxt_st.ev_mask;
      endcase
    end
    nxt_st.ev_stat = nxt_st.ev_stat | ev_set;

    // register reads, answered in the next cycle
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_EVT_STAT: nxt_st.rdata = {{(32-EV_W){1'b0}}, st_ff.ev_stat};
        OFS_EVT_MASK: nxt_st.rdata = {{(32-EV_W){1'b0}}, st_ff.ev_mask};
        OFS_ESR: nxt_st.rdata = {24'h000000, st_ff.esr};
        OFS_ESE: nxt_st.rdata = {24'h000000, st_ff.ese};
        OFS_SRE: nxt_st.rdata = {24'h000000, st_ff.sre};
        OFS_STB: nxt_st.rdata = {24'h000000, stb};
        OFS_TARGET: nxt_st.rdata = {27'h0000000, st_ff.target};
        OFS_MODE: nxt_st.rdata = {30'h00000000, st_ff.mode};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while the clock enable is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.esr <= ESR_RESET;
      st_ff.target <= TARGET_RESET; // [R10]
      st_ff.mode <= MODE_LOCAL;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign resp = st_ff.resp;
  assign flush = st_ff.flush;
  assign talk_en = st_ff.talk;
  assign listen_en = st_ff.listen;
  assign target_addr = st_ff.target;
  assign control_mode = st_ff.mode;
  assign srq = mss; // [R5]
  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.ev_stat & st_ff.ev_mask);

endmodule

// ---- core/cmd_handler_pkg.sv ----
package cmd_handler_pkg;

  // command codes delivered by the text parser
  typedef enum logic [2:0] {
    CMD_CLEAR_STATUS = 3'h0,
    CMD_RESET = 3'h1,
    CMD_OP_COMPLETE = 3'h2,
    CMD_WAIT = 3'h3,
    CMD_TARGET_SELECT = 3'h4,
    CMD_CONTROL_MODE = 3'h5
  } cmd_code_t;

  // control source encoding
  localparam logic [1:0] MODE_LOCAL = 2'h0;
  localparam logic [1:0] MODE_REMOTE = 2'h1;
  localparam logic [1:0] MODE_LOCKOUT = 2'h2;

  // local bus target address range and default
  localparam logic [4:0] TARGET_MIN = 5'h01;
  localparam logic [4:0] TARGET_MAX = 5'h1E;
  localparam logic [4:0] TARGET_RESET = 5'h01;

  // register byte offsets
  localparam logic [7:0] OFS_EVT_STAT = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK = 8'h04;
  localparam logic [7:0] OFS_ESR = 8'h08;
  localparam logic [7:0] OFS_ESE = 8'h0C;
  localparam logic [7:0] OFS_SRE = 8'h10;
  localparam logic [7:0] OFS_STB = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  localparam logic [7:0] OFS_MODE = 8'h1C;

  // standard event register bits
  localparam int ESR_OPC = 0;
  localparam int ESR_ALM = 3;
  localparam int ESR_EXE = 4;
  localparam int ESR_CME = 5;
  localparam int ESR_PON = 7;
  localparam logic [7:0] ESR_RESET = 8'h80;

  // status byte bits
  localparam int STB_TMO = 0;
  localparam int STB_LERR = 1;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  localparam logic [7:0] STB_SUMMARY_MASK = 8'hBF;

  // interrupt event bits
  localparam int EV_CLEAR = 0;
  localparam int EV_RESET = 1;
  localparam int EV_OPC = 2;
  localparam int EV_CMD_ERR = 3;
  localparam int EV_TARGET = 4;
  localparam int EV_MODE = 5;
  localparam int EV_W = 6;

  // answer value of the completion query
  localparam logic [7:0] OPC_ANSWER = 8'h01;

  typedef struct packed {
    logic valid;
    cmd_code_t code;
    logic query;
    logic [7:0] arg;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } resp_t;

  typedef struct packed {
    logic tx;
    logic rx;
    logic lbus;
    logic exec;
  } flush_t;

  typedef struct packed {
    logic [2:0] key_sync;
    logic key_level;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic tmo;
    logic lerr;
    logic [4:0] target;
    logic [1:0] mode;
    logic talk;
    logic listen;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    logic [31:0] rdata;
    resp_t resp;
    flush_t flush;
  } state_t;

endpackage

// ---- tb/cmd_handler_checker.sv ----
`timescale 1ns/1ps
module cmd_handler_checker
  import cmd_handler_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire cmd_t cmd,
  input wire resp_t resp,
  input wire flush_t flush,
  input wire logic talk_en,
  input wire logic listen_en,
  input wire logic [4:0] target_addr,
  input wire logic [1:0] control_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // command taken at this edge, setting form or query form
  wire logic set = ce && cmd.valid && !cmd.query;
  wire logic ask = ce && cmd.valid && cmd.query;
  ////////////////////////////////////////////////////////////////////////////////
  // mode query in local goes remote first, then answers
  sequence s_ask_local;
    ask && cmd.code == CMD_CONTROL_MODE && control_mode == MODE_LOCAL;
  endsequence
  sequence s_remote_answer;
    control_mode == MODE_REMOTE && resp.valid && resp.data == 8'h01;
  endsequence
  property p_mode_ask; s_ask_local |=> s_remote_answer; endproperty
  a_mode_ask: assert property (p_mode_ask) else $error("mode query answer");
  property p_opc_ask;
    ask && cmd.code == CMD_OP_COMPLETE |=> resp.valid && resp.data == OPC_ANSWER;
  endproperty
  a_opc_ask: assert property (p_opc_ask) else $error("completion answer");
  property p_clear; set && cmd.code == CMD_CLEAR_STATUS |=> flush == 4'hF; endproperty
  a_clear: assert property (p_clear) else $error("clear flush");
  property p_reset;
    set && cmd.code == CMD_RESET |=> flush == 4'hF && !talk_en && !listen_en;
  endproperty
  a_reset: assert property (p_reset) else $error("reset effects");
  property p_wait;
    set && cmd.code == CMD_WAIT |=> flush == 4'h0 && !resp.valid && $stable(target_addr);
  endproperty
  a_wait: assert property (p_wait) else $error("wait acted");
  property p_target;
    set && cmd.code == CMD_TARGET_SELECT && cmd.arg inside {[1:30]}
      |=> {3'h0, target_addr} == $past(cmd.arg);
  endproperty
  a_target: assert property (p_target) else $error("target select");
  property p_mode;
    set && cmd.code == CMD_CONTROL_MODE && cmd.arg < 8'h03
      |=> {6'h0, control_mode} == $past(cmd.arg);
  endproperty
  a_mode: assert property (p_mode) else $error("mode setting");
  property p_refuse;
    ask && cmd.code inside {CMD_CLEAR_STATUS, CMD_RESET, CMD_WAIT, CMD_TARGET_SELECT}
      |=> flush == 4'h0 && !resp.valid && $stable(target_addr);
  endproperty
  a_refuse: assert property (p_refuse) else $error("query form acted");
  property p_boot;
    $fell(rst) |-> target_addr == TARGET_RESET && control_mode == MODE_LOCAL;
  endproperty
  a_boot: assert property (p_boot) else $error("reset defaults");
endmodule
bind cmd_handler cmd_handler_checker u_chk (.mclk(mclk), .rst(rst), .ce(ce), .cmd(cmd),
  .resp(resp), .flush(flush), .talk_en(talk_en), .listen_en(listen_en),
  .target_addr(target_addr), .control_mode(control_mode));

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model
  import cmd_handler_pkg::*;
(
  input wire logic mclk,
  output cmd_t cmd
);
  // one command, held until the next rising edge takes it
  task automatic send(input cmd_code_t c, input logic q, input logic [7:0] a);
    cmd <= '{valid: 1'h1, code: c, query: q, arg: a};
    @(posedge mclk);
  endtask
  // drop valid; other fields flip so stale values never look meaningful
  task automatic idle();
    cmd <= cmd_t'({1'h0, ~cmd[11:0]});
    @(posedge mclk);
  endtask
  // hand the local bus back to the master unit when done with slaves
  task automatic end_lbus();
    send(CMD_TARGET_SELECT, 1'h0, 8'h01);
    idle();
  endtask
  initial cmd = '0;
endmodule

// ---- tb/test_remote_common_command_handler.sv ----
`timescale 1ns/1ps
module test_remote_common_command_handler
  import cmd_handler_pkg::*;
;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic ev = 1'h0;
  logic key = 1'h0;
  logic talk_set = 1'h0;
  logic listen_set = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic rd_d = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] t;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [4:0] target_addr;
  logic [1:0] control_mode;
  logic talk_en, listen_en, srq, irq;
  cmd_t cmd;
  resp_t resp;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 32'h4246;
  logic [31:0] rq[$];
  logic [31:0] aq[$];
  host_model u_host (.mclk(mclk), .cmd(cmd));
  cmd_handler dut (.mclk(mclk), .rst(rst), .ce(1'h1), .cmd(cmd), .resp(resp), .flush(),
    .panel_local_key(key), .talk_set(talk_set), .listen_set(listen_set), .exe_event(ev),
    .alarm_event(ev), .timeout_event(ev), .lbus_err_event(ev), .msg_avail(1'h0),
    .talk_en(talk_en), .listen_en(listen_en), .target_addr(target_addr),
    .control_mode(control_mode), .srq(srq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  initial forever #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(posedge mclk);
  endtask
  // note the expected word, then strobe the read
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic issue(input cmd_code_t c, input logic q, input logic [7:0] a);
    u_host.send(c, q, a);
    u_host.idle();
  endtask
  task automatic wrap_up();
    if (rq.size() != 0 || aq.size() != 0)
      fails++; // a note that no result ever answered
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watch answers and read data against the oldest note; bound the run
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (rd_d)
      chk(reg_rdata, rq.pop_front());
    if (resp.valid !== 1'h0)
      chk({24'h0, resp.data}, aq.size() != 0 ? aq.pop_front() : 32'hX);
    rd_d <= reg_rd;
    if (cyc == 2000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(OFS_TARGET, 32'h1);
    rd(OFS_ESR, 32'h80);
    ev <= 1'h1;
    @(posedge mclk);
    ev <= 1'h0;
    rd(OFS_ESR, 32'h98);
    issue(CMD_CLEAR_STATUS, 1'h0, 8'h00);
    rd(OFS_ESR, 32'h0);
    rd(OFS_STB, 32'h0);
    $display("test clear done");
    wr(OFS_ESE, 32'h1);
    wr(OFS_SRE, 32'h20);
    aq.push_back(32'h1);
    u_host.send(CMD_OP_COMPLETE, 1'h1, 8'h00);
    issue(CMD_OP_COMPLETE, 1'h0, 8'h00);
    rd(OFS_ESR, 32'h1);
    chk({31'h0, srq}, 32'h1);
    wr(OFS_SRE, 32'h0);
    chk({31'h0, srq}, 32'h0);
    wr(OFS_ESE, 32'h0);
    wr(OFS_SRE, 32'h20);
    chk({31'h0, srq}, 32'h0);
    wr(OFS_EVT_MASK, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EVT_STAT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    $display("test completion done");
    for (int m = 2; m >= 0; m--) begin
      issue(CMD_CONTROL_MODE, 1'h0, 8'(m));
      rd(OFS_MODE, 32'(m));
    end
    aq.push_back(32'h1);
    issue(CMD_CONTROL_MODE, 1'h1, 8'h00);
    rd(OFS_MODE, 32'h1);
    // panel key returns remote to local, but not lockout
    key <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(OFS_MODE, 32'h0);
    key <= 1'h0;
    issue(CMD_CONTROL_MODE, 1'h0, 8'h02);
    repeat (3) @(posedge mclk);
    key <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(OFS_MODE, 32'h2);
    key <= 1'h0;
    $display("test mode done");
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 8'h1E : 8'(($unsigned($random(seed)) % 30) + 1);
      issue(CMD_TARGET_SELECT, 1'h0, t);
      rd(OFS_TARGET, {24'h0, t});
    end
    rd(OFS_ESR, 32'h1);
    issue(CMD_TARGET_SELECT, 1'h0, 8'h1F);
    rd(OFS_TARGET, {24'h0, t});
    u_host.end_lbus();
    issue(CMD_WAIT, 1'h0, 8'h00);
    rd(OFS_TARGET, 32'h1);
    rd(OFS_ESR, 32'h11);
    issue(CMD_CLEAR_STATUS, 1'h1, 8'h00);
    rd(OFS_ESR, 32'h31);
    $display("test target and wait done");
    talk_set <= 1'h1;
    @(posedge mclk);
    talk_set <= 1'h0;
    listen_set <= 1'h1;
    @(posedge mclk);
    listen_set <= 1'h0;
    wr(OFS_ESE, 32'hFF);
    wr(OFS_SRE, 32'hFF);
    chk({30'h0, talk_en, listen_en}, 32'h3);
    issue(CMD_RESET, 1'h0, 8'h00);
    rd(OFS_ESE, 32'h0);
    rd(OFS_SRE, 32'h0);
    rd(OFS_ESR, 32'h0);
    chk({30'h0, talk_en, listen_en}, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    // refused forms leave state alone and flag a command error
    wr(OFS_ESE, 32'hFF);
    issue(CMD_RESET, 1'h1, 8'h00);
    rd(OFS_ESE, 32'hFF);
    issue(cmd_code_t'(3'h7), 1'h0, 8'h00);
    issue(CMD_CONTROL_MODE, 1'h0, 8'h03);
    rd(OFS_ESR, 32'h20);
    rd(OFS_MODE, 32'h2);
    $display("test refusals done");
    // second reset in mid-run brings back the defaults
    issue(CMD_TARGET_SELECT, 1'h0, 8'h05);
    rst <= 1'h1;
    repeat (2) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rd(OFS_TARGET, 32'h1);
    rd(OFS_MODE, 32'h0);
    rd(OFS_ESR, 32'h80);
    rd(OFS_ESE, 32'h0);
    $display("test mid-run reset done");
    @(posedge mclk);
    wrap_up();
  end
endmodule
